// file: rsh_defines.svh
/*
  Constants of the radio serial host: header fields, address ranges, status byte
  layout and link timing.
  Assumes inclusion by bare name from the package and the testbench.
*/
`ifndef RSH_DEFINES_SVH
`define RSH_DEFINES_SVH

// Header byte fields.
`define RSH_HDR_RW_BIT 7
`define RSH_HDR_BURST_BIT 6
`define RSH_HDR_ADDR_MSB 5

// Address ranges on the device side.
`define RSH_CFG_LAST 6'h2e
`define RSH_STAT_FIRST 6'h30
`define RSH_STAT_LAST 6'h3d
`define RSH_FIFO_ADDR 6'h3f
`define RSH_FIFO_SINGLE 8'hbf
`define RSH_FIFO_BURST 8'hff
`define RSH_RESET_STROBE 6'h30

// Status byte fields.
`define RSH_ST_RDY_BIT 7
`define RSH_ST_STATE_MSB 6
`define RSH_ST_STATE_LSB 4
`define RSH_ST_FILL_MSB 3

// Register offsets of the controller's own command port.
`define RSH_REG_CTRL 4'h0
`define RSH_REG_TXBYTE 4'h1
`define RSH_REG_RXBYTE 4'h2
`define RSH_REG_STATUS 4'h3
`define RSH_REG_DEVSTAT 4'h4

// Control register fields.
`define RSH_CTRL_GO_BIT 0
`define RSH_CTRL_LAST_BIT 1
`define RSH_CTRL_HDR_BIT 2

// Link timing: half period of the serial clock in ns, and the select lead time.
`define RSH_CLK_NS 20
`define RSH_HALF_NS 100
`define RSH_HALF_CYC ((`RSH_HALF_NS + `RSH_CLK_NS - 1) / `RSH_CLK_NS)
`define RSH_SETUP_NS 20
`define RSH_SETUP_CYC ((`RSH_SETUP_NS + `RSH_CLK_NS - 1) / `RSH_CLK_NS)

`endif

// file: rsh_pkg.sv
/*
  Types of the radio serial host.
  Assumes rsh_defines.svh is on the include path.
*/
`default_nettype none
package rsh_pkg;
  `include "rsh_defines.svh"

  // Software command port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rsh_req_t;

  // Serial pins driven by the host.
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic sel_n;
  } rsh_pins_t;

  // Main engine states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    RSH_IDLE = 3'b000,
    RSH_SEL = 3'b001,
    RSH_RDY = 3'b011,
    RSH_SHIFT = 3'b111,
    RSH_NEXT = 3'b110,
    RSH_DESEL = 3'b100,
    RSH_SOWAIT = 3'b010
  } rsh_state_t;
endpackage : rsh_pkg
`default_nettype wire

// file: rsh_sync.sv
/*
  Two-flop synchroniser for one level from outside the clock domain.
  Assumes a single clock and active-low asynchronous reset.
*/
`default_nettype none
module rsh_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_d,
  output logic o_q
);
  logic meta_reg;

  // The first flop is read only by the second, to contain metastability.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta_reg <= i_d;
      o_q <= meta_reg;
    end
  end
endmodule : rsh_sync
`default_nettype wire

// file: rsh_shifter.sv
/*
  Byte shifter for the serial link: one byte out MSB first, one byte in.
  Assumes a tick pulse per half serial period and a synchronised input.
*/
`default_nettype none
module rsh_shifter (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic [7:0] i_tx,
  input wire logic i_tick,
  input wire logic i_miso,
  output logic o_sclk,
  output logic o_mosi,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rx
);
  logic [3:0] half_reg;
  logic [7:0] tx_reg;

  // Low phase sets data, high phase samples it; the device samples on the rise.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      half_reg <= 4'h0;
      tx_reg <= 8'h00;
      o_sclk <= 1'b0;
      o_mosi <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_rx <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        o_busy <= 1'b1;
        half_reg <= 4'h0;
        tx_reg <= {i_tx[6:0], 1'b0};
        o_mosi <= i_tx[7];
      end else if (o_busy && i_tick) begin
        half_reg <= half_reg + 4'h1;
        if (!half_reg[0]) begin
          o_sclk <= 1'b1;
          o_rx <= {o_rx[6:0], i_miso};
        end else begin
          o_sclk <= 1'b0;
          if (half_reg == 4'hf) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
          end else begin
            o_mosi <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule : rsh_shifter
`default_nettype wire

// file: rsh_host.sv
/*
  Serial host controller for a low-power radio receiver's register port.
  Software writes a byte and a control word; the engine selects the device,
  waits for the ready bit, shifts the byte, and keeps or drops select.
  Assumes the device samples on the rising serial clock and answers MSB first.
*/
// Summary of operation
// - Header bit 7 set means read, clear means write.
// - A burst is all read or all write and ends when select rises.
// - Status registers are read-only, single access, writes ignored.
// - A strobe is one header byte with burst clear, status returned.
// - Set the read bit on strobes when the fill count matters.
// - Strobes may chain; after reset strobe wait for data-out low.
// - The 64-byte receive FIFO is at 0x3F, read bit set.
// - Header 0xBF reads one FIFO byte, 0xFF bursts the FIFO.
// - The FIFO flush strobe is legal only in idle or overflow state.
// - Hardware-updated status reads may corrupt; read twice and compare.
// - Ready-low must be low before the first serial clock rise.
`default_nettype none
module rsh_host
  import rsh_pkg::*;
(
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Software command port.
  input wire rsh_pkg::rsh_req_t I_REQ,
  output logic [7:0] O_RDATA,
  // Serial link pins.
  input wire logic I_MISO,
  output rsh_pkg::rsh_pins_t O_PINS
);
  import rsh_pkg::*;

  localparam int HALF_CYC = `RSH_HALF_CYC;
  localparam int SETUP_CYC = `RSH_SETUP_CYC;
  // Extra select lead so that the ready flag has crossed the synchroniser and the pin flop.
  localparam int SYNC_LAT = 2;
  initial begin
    if (HALF_CYC < 1 || SETUP_CYC < 1) begin
      $error("rsh_host: link timing must be at least one cycle");
    end
  end

  rsh_state_t state_reg;
  logic miso_s;
  logic [7:0] div_reg;
  logic tick;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [7:0] devstat_reg;
  logic go_reg;
  logic last_reg;
  logic hdr_reg;
  logic rst_wait_reg;
  logic sel_n_reg;
  logic [7:0] setup_reg;
  logic sh_start;
  logic sh_sclk;
  logic sh_mosi;
  logic sh_busy;
  logic sh_done;
  logic [7:0] sh_rx;
  logic err_reg;
  logic eng_free;

  // Data-out from the device is asynchronous to this clock.
  rsh_sync #(.RST_VAL(1'b1)) u_sync (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_d(I_MISO),
    .o_q(miso_s)
  );

  // Divider: one tick per half serial period.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      div_reg <= 8'h00;
    end else if (div_reg == 8'(HALF_CYC - 1)) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign tick = (div_reg == 8'(HALF_CYC - 1));

  // A fresh select or a byte chained after a reset strobe waits for ready-low; other chained bytes start straight from idle, because
  // data-out then carries the first bit of the next byte, not the ready flag.
  // ready gate
  assign sh_start = ((state_reg == RSH_RDY || state_reg == RSH_SOWAIT) && !miso_s)
      || (state_reg == RSH_IDLE && go_reg && !sel_n_reg && !rst_wait_reg);

  // A pending go counts as busy, so a second go or a new byte cannot slip in behind it.
  assign eng_free = (state_reg == RSH_IDLE) && !go_reg;

  rsh_shifter u_shift (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_start(sh_start),
    .i_tx(tx_reg),
    .i_tick(tick),
    .i_miso(miso_s),
    .o_sclk(sh_sclk),
    .o_mosi(sh_mosi),
    .o_busy(sh_busy),
    .o_done(sh_done),
    .o_rx(sh_rx)
  );

  // Software writes: the byte to send and the control word.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_reg <= 8'h00;
      last_reg <= 1'b1;
      hdr_reg <= 1'b1;
    end else if (I_REQ.wr && eng_free) begin
      if (I_REQ.addr == `RSH_REG_TXBYTE) begin
        tx_reg <= I_REQ.wdata;
      end else if (I_REQ.addr == `RSH_REG_CTRL) begin
        last_reg <= I_REQ.wdata[`RSH_CTRL_LAST_BIT];
        hdr_reg <= I_REQ.wdata[`RSH_CTRL_HDR_BIT];
      end
    end
  end

  // Go request; a go while busy is refused and flagged.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      go_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      go_reg <= I_REQ.wr && I_REQ.addr == `RSH_REG_CTRL && I_REQ.wdata[`RSH_CTRL_GO_BIT]
          && eng_free;
      if (I_REQ.wr && I_REQ.addr == `RSH_REG_CTRL && I_REQ.wdata[`RSH_CTRL_GO_BIT]
          && !eng_free) begin
        err_reg <= 1'b1;
      end else if (I_REQ.rd && I_REQ.addr == `RSH_REG_STATUS) begin
        err_reg <= 1'b0;
      end
    end
  end

  // Main engine: select, ready wait, shift, then hold or drop select.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_reg <= RSH_IDLE;
      sel_n_reg <= 1'b1;
      setup_reg <= 8'h00;
      rst_wait_reg <= 1'b0;
    end else begin
      case (state_reg)
        RSH_IDLE: begin
          if (go_reg) begin
            sel_n_reg <= 1'b0;
            setup_reg <= 8'h00;
            state_reg <= sel_n_reg ? RSH_SEL : (rst_wait_reg ? RSH_SOWAIT : RSH_SHIFT);
          end
        end
        RSH_SEL: begin
          setup_reg <= setup_reg + 8'h01;
          // Without the extra lead a stale deselected level would pass as ready.
          if (setup_reg >= 8'(SETUP_CYC + SYNC_LAT)) begin
            state_reg <= RSH_RDY;
          end
        end
        RSH_RDY: begin
          if (!miso_s) begin
            state_reg <= RSH_SHIFT;
          end
        end
        RSH_SHIFT: begin
          if (sh_done) begin
            state_reg <= RSH_NEXT;
          end
        end
        RSH_NEXT: begin
          rst_wait_reg <= hdr_reg && !tx_reg[`RSH_HDR_BURST_BIT]
              && tx_reg[`RSH_HDR_ADDR_MSB:0] == `RSH_RESET_STROBE;
          if (last_reg) begin
            state_reg <= RSH_DESEL;
          end else begin
            state_reg <= RSH_IDLE;
          end
        end
        RSH_SOWAIT: begin
          if (!miso_s) begin
            rst_wait_reg <= 1'b0;
            state_reg <= RSH_SHIFT;
          end
        end
        RSH_DESEL: begin
          sel_n_reg <= 1'b1;
          rst_wait_reg <= 1'b0;
          state_reg <= RSH_IDLE;
        end
        default: begin
          state_reg <= RSH_IDLE;
          sel_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // Capture of the returned byte; a header slot returns the status byte.
  // status byte capture
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_reg <= 8'h00;
      devstat_reg <= 8'h80;
    end else if (sh_done) begin
      rx_reg <= sh_rx;
      if (hdr_reg) begin
        devstat_reg <= sh_rx;
      end
    end
  end

  // Pins come straight from flops; data-out follows the shifter.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PINS <= '{sclk: 1'b0, mosi: 1'b0, sel_n: 1'b1};
    end else begin
      O_PINS <= '{sclk: sh_sclk, mosi: sh_mosi, sel_n: sel_n_reg};
    end
  end

  // Read port: data in the cycle after the read strobe, zero on unmapped.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RDATA <= 8'h00;
    end else if (I_REQ.rd) begin
      case (I_REQ.addr)
        `RSH_REG_CTRL: O_RDATA <= {5'h00, hdr_reg, last_reg, 1'b0};
        `RSH_REG_TXBYTE: O_RDATA <= tx_reg;
        `RSH_REG_RXBYTE: O_RDATA <= rx_reg;
        `RSH_REG_STATUS: O_RDATA <= {3'h0, err_reg, rst_wait_reg, state_reg};
        `RSH_REG_DEVSTAT: O_RDATA <= devstat_reg;
        default: O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

  // Link checks.
  property p_sel_before_clk;
    @(posedge I_CLK) disable iff (!I_NRST) $rose(O_PINS.sclk) |-> !O_PINS.sel_n;
  endproperty
  a_sel_before_clk: assert property (p_sel_before_clk)
    else $error("serial clock rose while deselected");

  property p_rdy_gate;
    @(posedge I_CLK) disable iff (!I_NRST) sh_start && state_reg != RSH_IDLE |-> !miso_s;
  endproperty
  a_rdy_gate: assert property (p_rdy_gate)
    else $error("byte started before ready-low");

  property p_byte_len;
    @(posedge I_CLK) disable iff (!I_NRST) sh_start |-> ##[1:200] sh_done;
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("byte did not finish in time");

  property p_desel_idle;
    @(posedge I_CLK) disable iff (!I_NRST) state_reg == RSH_DESEL |=> sel_n_reg;
  endproperty
  a_desel_idle: assert property (p_desel_idle)
    else $error("select did not rise at burst end");

  property p_clk_low_desel;
    @(posedge I_CLK) disable iff (!I_NRST) $rose(O_PINS.sel_n) |-> !O_PINS.sclk;
  endproperty
  a_clk_low_desel: assert property (p_clk_low_desel)
    else $error("select rose with clock high");

  property p_rst_wait;
    @(posedge I_CLK) disable iff (!I_NRST)
      state_reg == RSH_SOWAIT && miso_s |=> state_reg == RSH_SOWAIT;
  endproperty
  a_rst_wait: assert property (p_rst_wait)
    else $error("header sent before data-out low");

  property p_status_cap;
    @(posedge I_CLK) disable iff (!I_NRST) sh_done && hdr_reg |=> devstat_reg == $past(sh_rx);
  endproperty
  a_status_cap: assert property (p_status_cap)
    else $error("status byte not captured");

  property p_sel_steady;
    @(posedge I_CLK) disable iff (!I_NRST) sh_busy |-> !sel_n_reg;
  endproperty
  a_sel_steady: assert property (p_sel_steady)
    else $error("select high during a byte");

  property p_sync_lead;
    @(posedge I_CLK) disable iff (!I_NRST) $fell(sel_n_reg) |-> (state_reg == RSH_SEL) [*4];
  endproperty
  a_sync_lead: assert property (p_sync_lead)
    else $error("ready flag judged before it crossed the synchroniser");

  property p_chain_start;
    @(posedge I_CLK) disable iff (!I_NRST)
      state_reg == RSH_IDLE && go_reg && !sel_n_reg && !rst_wait_reg
      |=> state_reg == RSH_SHIFT && sh_busy;
  endproperty
  a_chain_start: assert property (p_chain_start)
    else $error("chained byte did not start at once");

  c_byte: cover property (@(posedge I_CLK) disable iff (!I_NRST) sh_done);
  c_chain: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      state_reg == RSH_NEXT && !last_reg);
  c_rstwait: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      state_reg == RSH_SOWAIT);
  c_fresh: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      state_reg == RSH_RDY && sh_start);
endmodule : rsh_host
`default_nettype wire

// file: rsh_dev_model.sv
/*
  Behavioural model of the radio's serial register port.
  Assumes an idle-low serial clock from the host, sampled on its rise.
*/
`default_nettype none
module rsh_dev_model (
  // Serial link.
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  output logic o_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:46];
  logic [7:0] sr, out_sr, nxt;
  logic [5:0] addr;
  logic rw, bst, hdr, rdy_n;
  int cnt, fifo_rd, n_err;

  function automatic logic [7:0] stat();
    return {rdy_n, 3'b000, (20 - fifo_rd > 15) ? 4'hf : 4'(20 - fifo_rd)};
  endfunction : stat

  function automatic logic [7:0] rd_val(input logic [5:0] a);
    if (a == 6'h3f) return 8'(8'h60 + fifo_rd);
    if (a >= 6'h30) return {2'b10, a};
    return mem[a];
  endfunction : rd_val

  // Crystal start-up holds ready-low high for a while.
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    fifo_rd = 0;
    n_err = 0;
    rdy_n = 1'b1;
    #1000 rdy_n = 1'b0;
  end

  // Any select edge restarts byte and header decoding.
  always @(i_sel_n) begin
    cnt = 0;
    hdr = 1'b1;
    out_sr = stat();
  end

  // Bits enter MSB first on the rising clock.
  always @(posedge i_sclk) begin
    if (!i_sel_n) begin
      // A clock while not ready is a host fault.
      if (rdy_n) n_err++;
      sr = {sr[6:0], i_mosi};
      cnt++;
      if (cnt == 8) begin
        cnt = 0;
        if (hdr) begin
          {rw, bst, addr} = sr;
          // Strobes are one byte and act at once.
          if (!bst && addr >= 6'h30 && addr <= 6'h3d) begin
            // Reset strobe clears and drops ready for a time.
            if (addr == 6'h30) begin
              foreach (mem[i]) mem[i] = 8'h00;
              rdy_n = 1'b1;
              rdy_n <= #2000 1'b0;
            end
            nxt = stat();
          end else begin
            hdr = 1'b0;
            // Writes echo status, reads give data.
            nxt = rw ? rd_val(addr) : stat();
          end
        end else begin
          if (!rw && addr <= 6'h2e) mem[addr] = sr;
          if (rw && addr == 6'h3f) fifo_rd++;
          // Burst steps on except at the FIFO address, single waits for a header.
          if (!bst) hdr = 1'b1;
          else if (addr != 6'h3f) addr++;
          nxt = (hdr || !rw) ? stat() : rd_val(addr);
        end
      end
    end
  end

  // Data-out drops as soon as the crystal is ready at a byte boundary.
  always @(negedge rdy_n) begin
    if (cnt == 0 && hdr) out_sr = stat();
  end

  // The next byte appears at the eighth fall, otherwise shift on.
  always @(negedge i_sclk) begin
    if (!i_sel_n) out_sr = (cnt == 0) ? nxt : {out_sr[6:0], 1'b0};
  end

  // Data-out while selected; a released line shows a stale inverse.
  assign o_miso = i_sel_n ? ~out_sr[7] : (rdy_n | out_sr[7]);
endmodule : rsh_dev_model
`default_nettype wire

// file: radio_spi_register_access_tb_top.sv
/*
  Self-checking bench of the radio serial host against the device model.
  Assumes the package, header and design modules are compiled first.
*/
`default_nettype none
`include "rsh_defines.svh"
module radio_spi_register_access_tb_top
  import rsh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, miso;
  logic [7:0] rdata;
  rsh_req_t req;
  rsh_pins_t pins;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  rsh_host uut (.I_CLK(clk), .I_NRST(nrst), .I_REQ(req), .O_RDATA(rdata),
    .I_MISO(miso), .O_PINS(pins));
  rsh_dev_model dev (.i_sclk(pins.sclk), .i_mosi(pins.mosi), .i_sel_n(pins.sel_n),
    .o_miso(miso));

  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // A hang is cut short; the full run needs far fewer cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe, taken mid-cycle.
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : reg_rd

  task automatic wait_done();
    logic [7:0] s;
    int k;
    repeat (4) @(posedge clk);
    s = 8'hff;
    k = 0;
    while (s[2:0] !== 3'b000 && k < 3000) begin
      reg_rd(`RSH_REG_STATUS, s);
      k++;
    end
    if (k >= 3000) begin
      n_mismatch++;
      $display("ERROR engine state expected 000 seen %b", s[2:0]);
    end
  endtask : wait_done

  // One byte over the link, then the returned byte is judged.
  task automatic xfer(input logic hdr, input logic last, input logic [7:0] tx,
    input logic [7:0] exp);
    logic [7:0] s;
    reg_wr(`RSH_REG_TXBYTE, tx);
    reg_wr(`RSH_REG_CTRL, {5'h00, hdr, last, 1'b1});
    wait_done();
    reg_rd(`RSH_REG_RXBYTE, s);
    chk("returned byte", exp, s);
    if (last) chk("select released", 8'h01, {7'h00, pins.sel_n});
  endtask : xfer

  task automatic t_reset();
    logic [7:0] d;
    chk("idle pins", 8'h01, {5'h00, pins});
    reg_rd(`RSH_REG_DEVSTAT, d);
    chk("device status at reset", 8'h80, d);
    reg_rd(4'hf, d);
    chk("unmapped read", 8'h00, d);
  endtask : t_reset

  // First access also waits out the crystal start-up.
  task automatic t_cfg();
    logic [7:0] d;
    xfer(1'b1, 1'b0, 8'h05, 8'h0f);
    xfer(1'b0, 1'b1, 8'ha5, 8'h0f);
    chk("stored register", 8'ha5, dev.mem[5]);
    xfer(1'b1, 1'b0, 8'h85, 8'h0f);
    xfer(1'b0, 1'b1, 8'h00, 8'ha5);
    reg_rd(`RSH_REG_DEVSTAT, d);
    chk("device status", 8'h0f, d);
  endtask : t_cfg

  task automatic t_burst();
    xfer(1'b1, 1'b0, 8'h4a, 8'h0f);
    for (int i = 0; i < 3; i++) xfer(1'b0, i == 2, 8'(8'h11 * (i + 1)), 8'h0f);
    xfer(1'b1, 1'b0, 8'hca, 8'h0f);
    for (int i = 0; i < 3; i++) xfer(1'b0, i == 2, 8'h00, 8'(8'h11 * (i + 1)));
    xfer(1'b1, 1'b0, 8'h75, 8'h0f);
    xfer(1'b0, 1'b1, 8'h5a, 8'h0f);
    xfer(1'b1, 1'b0, 8'hf5, 8'h0f);
    xfer(1'b0, 1'b1, 8'h00, 8'hb5);
  endtask : t_burst

  task automatic t_fifo();
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, 1'b0, 8'hbf, 8'h0f);
      xfer(1'b0, i == 1, 8'h00, 8'(8'h60 + i));
    end
    xfer(1'b1, 1'b0, 8'hff, 8'h0f);
    for (int i = 0; i < 5; i++) xfer(1'b0, i == 4, 8'h00, 8'(8'h62 + i));
    xfer(1'b1, 1'b1, 8'hbd, 8'h0d);
  endtask : t_fifo

  // Reset strobe chained to a read while select stays low.
  task automatic t_strobe();
    xfer(1'b1, 1'b0, 8'hb0, 8'h0d);
    xfer(1'b1, 1'b0, 8'h85, 8'h0d);
    xfer(1'b0, 1'b1, 8'h00, 8'h00);
    chk("clock while not ready", 8'h00, 8'(dev.n_err));
  endtask : t_strobe

  // A second go while busy is refused and flagged.
  task automatic t_busy();
    logic [7:0] s;
    reg_wr(`RSH_REG_TXBYTE, 8'hbd);
    reg_wr(`RSH_REG_CTRL, 8'h07);
    reg_wr(`RSH_REG_CTRL, 8'h07);
    reg_rd(`RSH_REG_STATUS, s);
    chk("refused go flag", 8'h01, {7'h00, s[4]});
    wait_done();
    reg_rd(`RSH_REG_STATUS, s);
    chk("flag cleared", 8'h00, {7'h00, s[4]});
    reg_rd(`RSH_REG_RXBYTE, s);
    chk("strobe status", 8'h0d, s);
  endtask : t_busy

  initial begin
    nrst = 1'b0;
    req = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_cfg();
    t_burst();
    t_fifo();
    t_strobe();
    t_busy();
    wrap_up();
  end
endmodule : radio_spi_register_access_tb_top
`default_nettype wire
